//--- verilog/hbu_host_bus_unit.v
// indirect host bus unit: command and data cycles to the register space
`timescale 1ns/100ps
`default_nettype none
`include "hbu_regs.vh"

module hbu_host_bus_unit
(
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        SELECT_N,
  input  wire        READ_STROBE_N,
  input  wire        WRITE_STROBE_N,
  input  wire        CMD_TYPE,
  input  wire        BUS_WIDTH_16,
  input  wire [15:0] SHARED_BUS_LINES_I,
  output wire [15:0] SHARED_BUS_LINES_O,
  output wire        SHARED_BUS_LINES_OE_N,
  input  wire        BYTE_ORDER_STRAP,
  input  wire        IRQ_PENDING,
  output wire        IRQ_REQUEST_N,
  output wire        BIG_ENDIAN,
  output wire [10:0] REG_ADDR,
  output wire [1:0]  REG_LANES,
  output wire [15:0] REG_WR_DATA,
  output wire        REG_WR_EN,
  output wire        REG_RD_EN,
  input  wire [15:0] REG_RD_DATA
);

  // stored command state
  reg  [10:0] addr_reg;
  reg  [3:0]  lanes_reg;
  reg         phase_reg;
  reg         endian_reg;
  reg         strap_done_reg;
  // register side request
  reg  [10:0] reg_addr_reg;
  reg  [1:0]  reg_lanes_reg;
  reg  [15:0] reg_wr_data_reg;
  reg         reg_wr_en_reg;
  reg         reg_rd_en_reg;
  reg         rd_wait_reg;
  // pin side
  reg  [15:0] bus_out_reg;
  reg         bus_oe_n_reg;
  reg         irq_n_reg;

  wire [1:0]  strobe_fall;
  wire        wr_event;
  wire        rd_event;
  reg  [10:0] eff_addr;
  reg  [1:0]  eff_lanes;
  reg  [15:0] wr_word;
  reg  [15:0] rd_word;
  reg         endian_hit;
  reg         endian_val;

  // strobe edges; bit 1 is write, bit 0 is read
  hbu_edge_det
  #(
    .WIDTH (2)
  )
  u_edges
  (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .level_n ({WRITE_STROBE_N, READ_STROBE_N}),
    .fall    (strobe_fall),
    .rise    ()
  );

  // select qualifies both strobes; no range decode here
  assign wr_event = strobe_fall[1] & ~SELECT_N;
  assign rd_event = strobe_fall[0] & ~SELECT_N;

  // effective address and lanes of the next data cycle
  always @*
  begin
    eff_addr  = addr_reg;
    eff_lanes = 2'b00;
    if (BUS_WIDTH_16)
    begin
      // low half of the dword when its lanes are enabled, else high half
      if (lanes_reg[1:0] != 2'b00)
      begin
        eff_addr  = {addr_reg[10:2], 2'b00};
        eff_lanes = lanes_reg[1:0];
      end
      else
      begin
        eff_addr  = {addr_reg[10:2], 2'b10};
        eff_lanes = lanes_reg[3:2];
      end
    end
    else if (addr_reg[0])
    begin
      eff_addr  = {addr_reg[10:1], 1'b0};
      eff_lanes = 2'b10;
    end
    else
      eff_lanes = 2'b01;
  end

  // write word seen by the register space, byte order applied in 16-bit mode
  always @*
  begin
    wr_word    = SHARED_BUS_LINES_I;
    endian_hit = 1'b0;
    endian_val = 1'b0;
    if (!BUS_WIDTH_16)
    begin
      // the byte is copied to both halves; lanes pick the live one
      wr_word = {SHARED_BUS_LINES_I[7:0],
                 SHARED_BUS_LINES_I[7:0]};
      endian_hit = (eff_addr == `HBU_RXFP_ADDR) && eff_lanes[1];
      endian_val = SHARED_BUS_LINES_I[`HBU_ENDIAN_HI_BIT];
    end
    else
    begin
      if (endian_reg)
        wr_word = {SHARED_BUS_LINES_I[7:0], SHARED_BUS_LINES_I[15:8]};
      endian_hit = (eff_addr == `HBU_RXFP_ADDR) && eff_lanes[1];
      endian_val = wr_word[`HBU_ENDIAN_BIT];
    end
  end

  // read word toward the bus; endian bit overlays the pointer register
  always @*
  begin
    rd_word = REG_RD_DATA;
    if (reg_addr_reg == `HBU_RXFP_ADDR)
      rd_word[`HBU_ENDIAN_BIT] = endian_reg;
    if (!BUS_WIDTH_16)
    begin
      if (reg_lanes_reg[1])
        rd_word = {8'h00, rd_word[15:8]};
      else
        rd_word = {8'h00, rd_word[7:0]};
    end
    else if (endian_reg)
      rd_word = {rd_word[7:0], rd_word[15:8]};
  end

  // command cycles store address, and lane enables in 16-bit mode only
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_reg  <= `HBU_ADDR_RST;
      lanes_reg <= `HBU_LANE_RST;
      phase_reg <= 1'b0;
    end
    else if (wr_event && CMD_TYPE)
    begin
      if (BUS_WIDTH_16)
      begin
        // lines 1:0 and 11 are ignored
        addr_reg  <= {SHARED_BUS_LINES_I[`HBU_CMD_ADDR_MSB:
                                         `HBU_CMD_ADDR_LSB], 2'b00};
        lanes_reg <= SHARED_BUS_LINES_I[`HBU_CMD_LANE_MSB:
                                        `HBU_CMD_LANE_LSB];
      end
      else if (!phase_reg)
      begin
        addr_reg[7:0] <= SHARED_BUS_LINES_I[7:0];
        phase_reg     <= 1'b1;
      end
      else
      begin
        addr_reg[10:8] <= SHARED_BUS_LINES_I[`HBU_CMD8_HI_MSB:0];
        phase_reg      <= 1'b0;
      end
    end
    else if ((wr_event || rd_event) && !CMD_TYPE)
      phase_reg <= 1'b0;   // a data cycle restarts the address pair
  end

  // byte order: strap caught once after release, then software wins
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      endian_reg     <= `HBU_ENDIAN_RST;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      endian_reg     <= ~BYTE_ORDER_STRAP;
      strap_done_reg <= 1'b1;
    end
    else if (wr_event && !CMD_TYPE && endian_hit)
      endian_reg <= endian_val;
  end

  // data cycles toward the register space; address is not advanced
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      reg_addr_reg    <= `HBU_ADDR_RST;
      reg_lanes_reg   <= 2'b00;
      reg_wr_data_reg <= `HBU_WORD_RST;
      reg_wr_en_reg   <= 1'b0;
      reg_rd_en_reg   <= 1'b0;
    end
    else
    begin
      reg_wr_en_reg <= 1'b0;
      reg_rd_en_reg <= 1'b0;
      if (wr_event && !CMD_TYPE)
      begin
        reg_addr_reg    <= eff_addr;
        reg_lanes_reg   <= eff_lanes;
        reg_wr_data_reg <= wr_word;
        reg_wr_en_reg   <= 1'b1;
      end
      else if (rd_event && !CMD_TYPE)
      begin
        reg_addr_reg  <= eff_addr;
        reg_lanes_reg <= eff_lanes;
        reg_rd_en_reg <= 1'b1;
      end
    end
  end

  // read return: the register space answers the cycle after the request
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_wait_reg  <= 1'b0;
      bus_out_reg  <= `HBU_WORD_RST;
      bus_oe_n_reg <= 1'b1;
    end
    else
    begin
      rd_wait_reg  <= reg_rd_en_reg;
      // drive only while selected and read held low
      bus_oe_n_reg <= SELECT_N | READ_STROBE_N;
      if (rd_event && CMD_TYPE && BUS_WIDTH_16)
        bus_out_reg <= {lanes_reg, 1'b0,
                        addr_reg[10:2], 2'b00};
      else if (rd_wait_reg)
        bus_out_reg <= rd_word;   // held until the next read loads the register
    end
  end

  // interrupt pin follows the pending request
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= ~IRQ_PENDING;
  end

  assign SHARED_BUS_LINES_O    = bus_out_reg;
  assign SHARED_BUS_LINES_OE_N = bus_oe_n_reg;
  assign IRQ_REQUEST_N         = irq_n_reg;
  assign BIG_ENDIAN            = endian_reg;
  assign REG_ADDR              = reg_addr_reg;
  assign REG_LANES             = reg_lanes_reg;
  assign REG_WR_DATA           = reg_wr_data_reg;
  assign REG_WR_EN             = reg_wr_en_reg;
  assign REG_RD_EN             = reg_rd_en_reg;

endmodule // hbu_host_bus_unit

`default_nettype wire

//--- verilog/hbu_regs.vh
// constants of the indirect host bus unit
`ifndef HBU_REGS_VH
`define HBU_REGS_VH

// register space: eleven address bits, 0x000 to 0x7ff
`define HBU_ADDR_W        11
`define HBU_ADDR_LAST     11'h7ff
`define HBU_DATA_W        16
`define HBU_LANE_W        4

// command word layout on the shared lines in 16-bit mode
`define HBU_CMD_ADDR_MSB  10
`define HBU_CMD_ADDR_LSB  2
`define HBU_CMD_LANE_MSB  15
`define HBU_CMD_LANE_LSB  12

// 8-bit mode: second command write carries address bits 10:8
`define HBU_CMD8_HI_MSB   2

// receive frame pointer register word and its byte order bit
`define HBU_RXFP_ADDR     11'h0f0
`define HBU_ENDIAN_BIT    11
`define HBU_ENDIAN_HI_BIT 3

// reset values
`define HBU_ADDR_RST      11'h000
`define HBU_LANE_RST      4'h0
`define HBU_WORD_RST      16'h0000
`define HBU_ENDIAN_RST    1'b0

`endif

//--- verilog/hbu_edge_det.v
// per-bit edge detector for the active-low host strobes
`timescale 1ns/100ps
`default_nettype none

module hbu_edge_det
#(
  parameter WIDTH = 2
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] level_n,
  output wire [WIDTH-1:0] fall,
  output wire [WIDTH-1:0] rise
);

  reg [WIDTH-1:0] prev_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // idle strobes are high, so reset to high avoids a false fall
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          prev_reg[i] <= 1'b1;
        else
          prev_reg[i] <= level_n[i];
      end
      assign fall[i] = prev_reg[i] & ~level_n[i];
      assign rise[i] = ~prev_reg[i] & level_n[i];
    end
  endgenerate

endmodule // hbu_edge_det

`default_nettype wire

//--- tb/hbu_checker.sv
// bound assertions on the host bus unit ports
`timescale 1ns/100ps
`default_nettype none
module hbu_checker
(
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        SELECT_N,
  input wire logic        READ_STROBE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        CMD_TYPE,
  input wire logic        BUS_WIDTH_16,
  input wire logic [15:0] SHARED_BUS_LINES_I,
  input wire logic        SHARED_BUS_LINES_OE_N,
  input wire logic        IRQ_PENDING,
  input wire logic        IRQ_REQUEST_N,
  input wire logic [1:0]  REG_LANES,
  input wire logic [15:0] REG_WR_DATA,
  input wire logic        REG_WR_EN,
  input wire logic        REG_RD_EN
);
  logic [7:0] lo_q;
  // qualified strobes, so $past sees plain signals
  wire logic rd_off = SELECT_N | READ_STROBE_N;
  wire logic rd_go  = !rd_off && !CMD_TYPE;
  wire logic wr_go  = !SELECT_N && !WRITE_STROBE_N && !CMD_TYPE;
  // low byte as the design sampled it
  always @(posedge REF_CLK) lo_q <= SHARED_BUS_LINES_I[7:0];
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_irq_level: assert property ($past(RST_N) |->
    IRQ_REQUEST_N == !$past(IRQ_PENDING)) else $error("irq pin");
  a_oe_follow: assert property ($past(RST_N) |->
    SHARED_BUS_LINES_OE_N == $past(rd_off)) else $error("bus enable");
  a_wr_cause: assert property (REG_WR_EN |->
    $past(wr_go) && $past(WRITE_STROBE_N, 2)) else $error("write");
  a_rd_cause: assert property (REG_RD_EN |->
    $past(rd_go) && $past(READ_STROBE_N, 2)) else $error("read");
  a_wr_single: assert property (REG_WR_EN |=>
    !REG_WR_EN) else $error("write repeats");
  a_rd_single: assert property (REG_RD_EN |=>
    !REG_RD_EN [*3]) else $error("read repeats");
  a_byte_only: assert property (REG_WR_EN && !BUS_WIDTH_16 |->
    REG_LANES inside {2'h1, 2'h2}) else $error("byte lanes");
  a_byte_dup: assert property (REG_WR_EN && !BUS_WIDTH_16 |->
    REG_WR_DATA == {lo_q, lo_q}) else $error("byte data");
  c_wr16: cover property (REG_WR_EN && BUS_WIDTH_16);
  c_wr8: cover property (REG_WR_EN && !BUS_WIDTH_16);
  c_irq: cover property ($fell(IRQ_REQUEST_N));
endmodule // hbu_checker
bind hbu_host_bus_unit hbu_checker u_chk (.REF_CLK, .RST_N, .SELECT_N,
  .READ_STROBE_N, .WRITE_STROBE_N, .CMD_TYPE, .BUS_WIDTH_16,
  .SHARED_BUS_LINES_I, .SHARED_BUS_LINES_OE_N, .IRQ_PENDING,
  .IRQ_REQUEST_N, .REG_LANES, .REG_WR_DATA, .REG_WR_EN, .REG_RD_EN);
`default_nettype wire

//--- tb/hbu_reg_model.sv
// register space behind the host bus unit
`timescale 1ns/100ps
`default_nettype none
module hbu_reg_model
(
  input  wire logic        clk,
  input  wire logic [10:0] addr,
  input  wire logic [1:0]  lanes,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output var  logic [15:0] rd_data
);
  logic [15:0] mem [0:1023];
  initial rd_data = 16'h0;
  // enabled lanes only; idle read lines toggle so late samples show
  always @(posedge clk)
  begin
    if (wr_en && lanes[0]) mem[addr[10:1]][7:0] <= wr_data[7:0];
    if (wr_en && lanes[1]) mem[addr[10:1]][15:8] <= wr_data[15:8];
    rd_data <= rd_en ? mem[addr[10:1]] : ~rd_data;
  end
endmodule // hbu_reg_model
`default_nettype wire

//--- tb/hbu_host_bus_unit_test.sv
// self-checking bench for the host bus unit
`timescale 1ns/100ps
`default_nettype none
module hbu_host_bus_unit_test;
  logic        clk = 0, rst_n = 0, sel_n = 1, rd_n = 1, wr_n = 1;
  logic        cmd = 0, w16 = 1, strap = 1, irq = 0;
  logic        oe_n, oe_v, irq_n, big, wen, ren;
  logic [15:0] din = 0, dout, wdata, rdata, rd_v, w_data;
  logic [10:0] addr, w_addr;
  logic [1:0]  lanes, w_lanes;
  int          err_total = 0, n_tests = 0, wcnt = 0;
  always #50 clk = ~clk;
  // count write pulses to catch unselected strobes
  always @(posedge clk) if (wen) wcnt++;
  hbu_host_bus_unit u_dut (.REF_CLK(clk), .RST_N(rst_n), .SELECT_N(sel_n),
    .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .CMD_TYPE(cmd),
    .BUS_WIDTH_16(w16), .SHARED_BUS_LINES_I(din),
    .SHARED_BUS_LINES_O(dout), .SHARED_BUS_LINES_OE_N(oe_n),
    .BYTE_ORDER_STRAP(strap), .IRQ_PENDING(irq), .IRQ_REQUEST_N(irq_n),
    .BIG_ENDIAN(big), .REG_ADDR(addr), .REG_LANES(lanes),
    .REG_WR_DATA(wdata), .REG_WR_EN(wen), .REG_RD_EN(ren),
    .REG_RD_DATA(rdata));
  hbu_reg_model u_mem (.clk(clk), .addr(addr), .lanes(lanes),
    .wr_data(wdata), .wr_en(wen), .rd_en(ren), .rd_data(rdata));
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic s);
    rst_n = 0;
    strap = s;
    repeat (6) @(posedge clk);
    #10;
    rst_n = 1;
    repeat (2) @(posedge clk);
    #10;
    chk(big, !s);
  endtask
  // one strobe held to the sampled edge; snapshot after the answer
  // c plays the host address line that feeds command type
  // select low per access also stands for a tied-low select
  task automatic bus(input logic s, c, wr, input logic [15:0] d);
    @(posedge clk);
    #10;
    {sel_n, cmd, din} = {s, c, d};
    if (wr) wr_n = 0;
    else rd_n = 0;
    repeat (wr ? 2 : 5) @(posedge clk);
    #10;
    // read data taken just before the strobe rises, off the edge
    {rd_v, oe_v} = {dout, oe_n};
    {w_addr, w_lanes, w_data} = {addr, lanes, wdata};
    {sel_n, rd_n, wr_n} = 3'h7;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_word16;
    bus(0, 1, 1, 16'h30d0);
    bus(0, 0, 1, 16'h1234);
    chk({3'h0, w_lanes, w_addr}, 16'h18d0);
    chk(w_data, 16'h1234);
    chk(oe_v, 1);
    bus(0, 0, 1, 16'h5678);
    chk({5'h0, w_addr}, 16'h00d0);
    bus(0, 1, 0, 16'h0);
    chk(rd_v, 16'h30d0);
    bus(0, 0, 0, 16'h0);
    chk(rd_v, 16'h5678);
    chk(oe_v, 0);
  endtask
  // lane patterns 1, 2, 0xc and 4; ignored lines set in the first
  task automatic t_lanes;
    logic [15:0] c [4] = '{16'h18d3, 16'h20d0, 16'hc0d0, 16'h40d0};
    logic [15:0] e [4] = '{16'h08d0, 16'h10d0, 16'h18d2, 16'h08d2};
    for (int i = 0; i < 4; i++)
    begin
      bus(0, 1, 1, c[i]);
      bus(0, 0, 1, 16'hbeef);
      chk({3'h0, w_lanes, w_addr}, e[i]);
    end
  endtask
  task automatic t_select;
    int n;
    n = wcnt;
    bus(1, 0, 1, 16'h1111);
    chk(wcnt[15:0], n[15:0]);
  endtask
  // pointer word writes set bit 11 on purpose only
  task automatic t_endian;
    bus(0, 1, 1, 16'h30f0);
    bus(0, 0, 1, 16'h0800);
    chk(big, 1);
    bus(0, 1, 1, 16'h30d0);
    bus(0, 0, 1, 16'h1234);
    chk(w_data, 16'h3412);
    bus(0, 0, 0, 16'h0);
    chk(rd_v, 16'h1234);
    bus(0, 1, 1, 16'h30f0);
    bus(0, 0, 1, 16'h0);
    chk(big, 0);
  endtask
  task automatic t_irq;
    #10;
    irq = 1;
    repeat (2) @(posedge clk);
    #10;
    chk(irq_n, 0);
    irq = 0;
    repeat (2) @(posedge clk);
    #10;
    chk(irq_n, 1);
  endtask
  // byte bus after a second reset, big endian strap
  // no command read-back is tried in byte mode
  task automatic t_byte8;
    w16 = 0;
    do_reset(0);
    bus(0, 1, 1, 16'hff55);
    bus(0, 1, 1, 16'hf807);
    bus(0, 0, 1, 16'hffa5);
    chk({3'h0, w_lanes, w_addr}, 16'h1754);
    chk(w_data, 16'ha5a5);
    bus(0, 0, 0, 16'h0);
    chk(rd_v[7:0], 8'ha5);
  endtask
  initial
  begin
    do_reset(1);
    t_word16;
    t_lanes;
    t_select;
    t_endian;
    t_irq;
    t_byte8;
    test_done;
  end
  // a hang ends the run as a failure
  initial
  begin
    #1000000;
    err_total++;
    test_done;
  end
endmodule // hbu_host_bus_unit_test
`default_nettype wire
